// File: ccdhb_blank_gen.sv
// Behaviour
// - Mode 1 repeats blank pattern per settings
// - Even/odd lines use own toggle sets
// - Line alternation independent of vertical alternation
// - Wide clock field bits 7:4 at 0x34
// - Wide setting N gives pixel rate over 2N
// - Slow clocks only inside blanking
// - No widening in mode 2
// - Mode 2 splits blanking into six areas
// - Areas share starts A, B, C
// - Zero count suppresses that pulse group
// - Separate phase 1 and phase 2 counts
// - Odd lines reorder even-line areas only
// - Six 3-bit odd-line area selects
// - Clamp mask suppresses clamp on lines
// - Starts are 13-bit, unused set 8191
// - Count register holds A, B, C nibbles
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ccdhb_blank_gen #(
   parameter int PIXEL_DIV = ccdhb_pkg::PIXEL_DIV
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ccdhb_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic line_start,
   input wire logic clamp_request,
   output logic horizontal_blanking,
   output logic horiz_clock_phase_1,
   output logic horiz_clock_phase_2,
   output logic optical_black_clamp
);
   localparam int PW = ccdhb_pkg::POS_W;
   localparam int RW = 3 * ccdhb_pkg::CNT_W;
   localparam int SW = ccdhb_pkg::SEL_W;

   // Register file
   logic [ccdhb_pkg::MODE_W-1:0] blanking_mode_select;
   logic clamp_line_mask_even;
   logic clamp_line_mask_odd;
   logic [PW-1:0] blank_repeat_start;
   logic [PW-1:0] blank_repeat_end;
   logic [PW-1:0] blank_repeat_length;
   logic [PW-1:0] blank_repeat_count;
   logic [ccdhb_pkg::WIDE_W-1:0] wide_clock_divider;
   logic [PW-1:0] even_line_toggle_positions [ccdhb_pkg::TOGS];
   logic [PW-1:0] odd_line_toggle_positions [ccdhb_pkg::TOGS];
   logic [RW-1:0] area_phase1_repeat_count [ccdhb_pkg::AREAS];
   logic [RW-1:0] area_phase2_repeat_count [ccdhb_pkg::AREAS];
   logic [PW-1:0] area_start_position_a;
   logic [PW-1:0] area_start_position_b;
   logic [PW-1:0] area_start_position_c;
   logic [SW-1:0] odd_line_area_select [ccdhb_pkg::AREAS];
   logic [ccdhb_pkg::MODE_W-1:0] next_blanking_mode_select;
   logic next_clamp_line_mask_even;
   logic next_clamp_line_mask_odd;
   logic [PW-1:0] next_blank_repeat_start;
   logic [PW-1:0] next_blank_repeat_end;
   logic [PW-1:0] next_blank_repeat_length;
   logic [PW-1:0] next_blank_repeat_count;
   logic [ccdhb_pkg::WIDE_W-1:0] next_wide_clock_divider;
   logic [PW-1:0] next_even_line_toggle_positions [ccdhb_pkg::TOGS];
   logic [PW-1:0] next_odd_line_toggle_positions [ccdhb_pkg::TOGS];
   logic [RW-1:0] next_area_phase1_repeat_count [ccdhb_pkg::AREAS];
   logic [RW-1:0] next_area_phase2_repeat_count [ccdhb_pkg::AREAS];
   logic [PW-1:0] next_area_start_position_a;
   logic [PW-1:0] next_area_start_position_b;
   logic [PW-1:0] next_area_start_position_c;
   logic [SW-1:0] next_odd_line_area_select [ccdhb_pkg::AREAS];

   // Bus slave state
   logic access_done;
   logic next_access_done;
   logic [31:0] next_prdata;
   logic [31:0] rd_data;
   logic addr_ok;
   logic wr_en;
   logic [ccdhb_pkg::ADDR_W-1:0] offs;
   logic [2:0] idx;

   // Line timing state
   logic [PW-1:0] pos;
   logic [PW-1:0] next_pos;
   logic line_odd;
   logic next_line_odd;
   logic [PW-1:0] rep_pos;
   logic [PW-1:0] next_rep_pos;
   logic [PW-1:0] rep_idx;
   logic [PW-1:0] next_rep_idx;
   logic [ccdhb_pkg::WIDE_W-1:0] wide_cnt;
   logic [ccdhb_pkg::WIDE_W-1:0] next_wide_cnt;
   logic wide_phase;
   logic next_wide_phase;
   logic next_horizontal_blanking;
   logic next_horiz_clock_phase_1;
   logic next_horiz_clock_phase_2;
   logic next_optical_black_clamp;

   logic pixel_tick;
   logic first_half;
   logic in_win;
   logic blank_now;
   logic wide_on;
   logic tog_par;
   logic [PW-1:0] tog_ref;
   logic [SW-1:0] area_sel;
   logic [RW-1:0] sel_ph1;
   logic [RW-1:0] sel_ph2;
   logic hit_ph1;
   logic hit_ph2;

   ccdhb_pixel_div #(
      .DIV(PIXEL_DIV)
   ) u_pixel_div (
      .pclk(pclk),
      .presetn(presetn),
      .restart(line_start),
      .pixel_tick(pixel_tick),
      .first_half(first_half)
   );

   // APB: one wait state so read data comes from a flip-flop
   assign pready = access_done;
   assign pslverr = access_done && !addr_ok;
   assign wr_en = psel && penable && access_done && pwrite && addr_ok;

   function automatic logic in_array(input logic [ccdhb_pkg::ADDR_W-1:0] a,
                                     input logic [ccdhb_pkg::ADDR_W-1:0] base);
      in_array = a >= base && a < base + ccdhb_pkg::ARRAY_SPAN && a[1:0] == 2'h0;
   endfunction

   always_comb
   begin
      next_access_done = psel && penable && !access_done;
      offs = '0;
      rd_data = '0;
      addr_ok = 1'b1;
      if (in_array(paddr, ccdhb_pkg::ADR_TOG_EVEN))
         offs = paddr - ccdhb_pkg::ADR_TOG_EVEN;
      else if (in_array(paddr, ccdhb_pkg::ADR_TOG_ODD))
         offs = paddr - ccdhb_pkg::ADR_TOG_ODD;
      else if (in_array(paddr, ccdhb_pkg::ADR_REP_PH1))
         offs = paddr - ccdhb_pkg::ADR_REP_PH1;
      else if (in_array(paddr, ccdhb_pkg::ADR_REP_PH2))
         offs = paddr - ccdhb_pkg::ADR_REP_PH2;
      idx = offs[4:2];
      if (in_array(paddr, ccdhb_pkg::ADR_TOG_EVEN))
         rd_data[PW-1:0] = even_line_toggle_positions[idx];
      else if (in_array(paddr, ccdhb_pkg::ADR_TOG_ODD))
         rd_data[PW-1:0] = odd_line_toggle_positions[idx];
      else if (in_array(paddr, ccdhb_pkg::ADR_REP_PH1))
         rd_data[RW-1:0] = area_phase1_repeat_count[idx];
      else if (in_array(paddr, ccdhb_pkg::ADR_REP_PH2))
         rd_data[RW-1:0] = area_phase2_repeat_count[idx];
      else
      begin
         case (paddr)
            ccdhb_pkg::ADR_CTRL:
            begin
               rd_data[ccdhb_pkg::CTRL_MODE_LSB +: ccdhb_pkg::MODE_W] = blanking_mode_select;
               rd_data[ccdhb_pkg::CTRL_MASK_EVEN_BIT] = clamp_line_mask_even;
               rd_data[ccdhb_pkg::CTRL_MASK_ODD_BIT] = clamp_line_mask_odd;
            end
            ccdhb_pkg::ADR_BLK_START: rd_data[PW-1:0] = blank_repeat_start;
            ccdhb_pkg::ADR_BLK_END: rd_data[PW-1:0] = blank_repeat_end;
            ccdhb_pkg::ADR_BLK_LEN: rd_data[PW-1:0] = blank_repeat_length;
            ccdhb_pkg::ADR_BLK_REP: rd_data[PW-1:0] = blank_repeat_count;
            ccdhb_pkg::ADR_STATUS:
            begin
               rd_data[PW-1:0] = pos;
               rd_data[ccdhb_pkg::STATUS_ODD_BIT] = line_odd;
               rd_data[ccdhb_pkg::STATUS_BLANK_BIT] = horizontal_blanking;
            end
            ccdhb_pkg::ADR_WIDE:
               rd_data[ccdhb_pkg::WIDE_LSB +: ccdhb_pkg::WIDE_W] = wide_clock_divider;
            ccdhb_pkg::ADR_START_A: rd_data[PW-1:0] = area_start_position_a;
            ccdhb_pkg::ADR_START_B: rd_data[PW-1:0] = area_start_position_b;
            ccdhb_pkg::ADR_START_C: rd_data[PW-1:0] = area_start_position_c;
            ccdhb_pkg::ADR_ALT_SEL:
               for (int k = 0; k < ccdhb_pkg::AREAS; k++)
                  rd_data[k*SW +: SW] = odd_line_area_select[k];
            default: addr_ok = 1'b0;
         endcase
      end
      next_prdata = (psel && penable && !access_done) ? rd_data : prdata;
   end

   always_comb
   begin
      next_blanking_mode_select = blanking_mode_select;
      next_clamp_line_mask_even = clamp_line_mask_even;
      next_clamp_line_mask_odd = clamp_line_mask_odd;
      next_blank_repeat_start = blank_repeat_start;
      next_blank_repeat_end = blank_repeat_end;
      next_blank_repeat_length = blank_repeat_length;
      next_blank_repeat_count = blank_repeat_count;
      next_wide_clock_divider = wide_clock_divider;
      next_even_line_toggle_positions = even_line_toggle_positions;
      next_odd_line_toggle_positions = odd_line_toggle_positions;
      next_area_phase1_repeat_count = area_phase1_repeat_count;
      next_area_phase2_repeat_count = area_phase2_repeat_count;
      next_area_start_position_a = area_start_position_a;
      next_area_start_position_b = area_start_position_b;
      next_area_start_position_c = area_start_position_c;
      next_odd_line_area_select = odd_line_area_select;
      if (wr_en)
      begin
         if (in_array(paddr, ccdhb_pkg::ADR_TOG_EVEN))
            next_even_line_toggle_positions[idx] = pwdata[PW-1:0];
         else if (in_array(paddr, ccdhb_pkg::ADR_TOG_ODD))
            next_odd_line_toggle_positions[idx] = pwdata[PW-1:0];
         else if (in_array(paddr, ccdhb_pkg::ADR_REP_PH1))
            next_area_phase1_repeat_count[idx] = pwdata[RW-1:0];
         else if (in_array(paddr, ccdhb_pkg::ADR_REP_PH2))
            next_area_phase2_repeat_count[idx] = pwdata[RW-1:0];
         else
         begin
            case (paddr)
               ccdhb_pkg::ADR_CTRL:
               begin
                  next_blanking_mode_select = pwdata[ccdhb_pkg::CTRL_MODE_LSB +: ccdhb_pkg::MODE_W];
                  next_clamp_line_mask_even = pwdata[ccdhb_pkg::CTRL_MASK_EVEN_BIT];
                  next_clamp_line_mask_odd = pwdata[ccdhb_pkg::CTRL_MASK_ODD_BIT];
               end
               ccdhb_pkg::ADR_BLK_START: next_blank_repeat_start = pwdata[PW-1:0];
               ccdhb_pkg::ADR_BLK_END: next_blank_repeat_end = pwdata[PW-1:0];
               ccdhb_pkg::ADR_BLK_LEN: next_blank_repeat_length = pwdata[PW-1:0];
               ccdhb_pkg::ADR_BLK_REP: next_blank_repeat_count = pwdata[PW-1:0];
               ccdhb_pkg::ADR_WIDE:
                  next_wide_clock_divider = pwdata[ccdhb_pkg::WIDE_LSB +: ccdhb_pkg::WIDE_W];
               ccdhb_pkg::ADR_START_A: next_area_start_position_a = pwdata[PW-1:0];
               ccdhb_pkg::ADR_START_B: next_area_start_position_b = pwdata[PW-1:0];
               ccdhb_pkg::ADR_START_C: next_area_start_position_c = pwdata[PW-1:0];
               ccdhb_pkg::ADR_ALT_SEL:
                  for (int k = 0; k < ccdhb_pkg::AREAS; k++)
                     next_odd_line_area_select[k] = pwdata[k*SW +: SW];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         access_done <= 1'b0;
         prdata <= '0;
         blanking_mode_select <= ccdhb_pkg::MODE_TOGGLE;
         clamp_line_mask_even <= 1'b0;
         clamp_line_mask_odd <= 1'b0;
         blank_repeat_start <= ccdhb_pkg::POS_ZERO;
         blank_repeat_end <= ccdhb_pkg::POS_ZERO;
         blank_repeat_length <= ccdhb_pkg::POS_ZERO;
         blank_repeat_count <= ccdhb_pkg::POS_ZERO;
         wide_clock_divider <= '0;
         for (int k = 0; k < ccdhb_pkg::TOGS; k++)
         begin
            even_line_toggle_positions[k] <= ccdhb_pkg::POS_MAX;
            odd_line_toggle_positions[k] <= ccdhb_pkg::POS_MAX;
         end
         for (int k = 0; k < ccdhb_pkg::AREAS; k++)
         begin
            area_phase1_repeat_count[k] <= '0;
            area_phase2_repeat_count[k] <= '0;
            odd_line_area_select[k] <= SW'(k);
         end
         area_start_position_a <= ccdhb_pkg::POS_MAX;
         area_start_position_b <= ccdhb_pkg::POS_MAX;
         area_start_position_c <= ccdhb_pkg::POS_MAX;
      end
      else
      begin
         access_done <= next_access_done;
         prdata <= next_prdata;
         blanking_mode_select <= next_blanking_mode_select;
         clamp_line_mask_even <= next_clamp_line_mask_even;
         clamp_line_mask_odd <= next_clamp_line_mask_odd;
         blank_repeat_start <= next_blank_repeat_start;
         blank_repeat_end <= next_blank_repeat_end;
         blank_repeat_length <= next_blank_repeat_length;
         blank_repeat_count <= next_blank_repeat_count;
         wide_clock_divider <= next_wide_clock_divider;
         even_line_toggle_positions <= next_even_line_toggle_positions;
         odd_line_toggle_positions <= next_odd_line_toggle_positions;
         area_phase1_repeat_count <= next_area_phase1_repeat_count;
         area_phase2_repeat_count <= next_area_phase2_repeat_count;
         area_start_position_a <= next_area_start_position_a;
         area_start_position_b <= next_area_start_position_b;
         area_start_position_c <= next_area_start_position_c;
         odd_line_area_select <= next_odd_line_area_select;
      end
   end

   // Mode 2 area lookup; odd lines borrow an even-line area unchanged
   always_comb
   begin
      area_sel = rep_idx[SW-1:0];
      if (line_odd)
         area_sel = odd_line_area_select[rep_idx[SW-1:0]];
      if (area_sel < SW'(ccdhb_pkg::AREAS))
      begin
         sel_ph1 = area_phase1_repeat_count[area_sel];
         sel_ph2 = area_phase2_repeat_count[area_sel];
      end
      else
      begin
         // Out-of-range select yields an empty area
         sel_ph1 = '0;
         sel_ph2 = '0;
      end
   end

   ccdhb_group_hit u_hit_ph1 (
      .local_pos(rep_pos),
      .start_a(area_start_position_a),
      .start_b(area_start_position_b),
      .start_c(area_start_position_c),
      .counts(sel_ph1),
      .hit(hit_ph1)
   );

   ccdhb_group_hit u_hit_ph2 (
      .local_pos(rep_pos),
      .start_a(area_start_position_a),
      .start_b(area_start_position_b),
      .start_c(area_start_position_c),
      .counts(sel_ph2),
      .hit(hit_ph2)
   );

   // Line timing and horizontal clock generation
   always_comb
   begin
      in_win = pos >= blank_repeat_start && pos < blank_repeat_end;
      tog_ref = (blanking_mode_select == ccdhb_pkg::MODE_REPEAT) ? rep_pos : pos;
      tog_par = 1'b0;
      // Blank level is the parity of toggle positions already passed
      for (int k = 0; k < ccdhb_pkg::TOGS; k++)
         tog_par = tog_par ^ (tog_ref >= (line_odd ? odd_line_toggle_positions[k]
                                                   : even_line_toggle_positions[k]));
      case (blanking_mode_select)
         ccdhb_pkg::MODE_TOGGLE: blank_now = tog_par;
         ccdhb_pkg::MODE_REPEAT: blank_now = in_win && rep_idx < blank_repeat_count && tog_par;
         ccdhb_pkg::MODE_AREA: blank_now = in_win && rep_idx < PW'(ccdhb_pkg::AREAS);
         default: blank_now = 1'b0;
      endcase
      wide_on = blank_now && wide_clock_divider != '0 &&
                blanking_mode_select != ccdhb_pkg::MODE_AREA;

      next_pos = pos;
      next_line_odd = line_odd;
      next_rep_pos = rep_pos;
      next_rep_idx = rep_idx;
      if (line_start)
      begin
         next_pos = ccdhb_pkg::POS_ZERO;
         next_line_odd = !line_odd;
         next_rep_pos = ccdhb_pkg::POS_ZERO;
         next_rep_idx = ccdhb_pkg::POS_ZERO;
      end
      else if (pixel_tick)
      begin
         if (pos != ccdhb_pkg::POS_MAX)
            next_pos = pos + 1'b1;
         if (in_win)
         begin
            // Repeat period and mode 2 area length share one counter
            if (rep_pos + 1'b1 >= blank_repeat_length)
            begin
               next_rep_pos = ccdhb_pkg::POS_ZERO;
               if (rep_idx != ccdhb_pkg::POS_MAX)
                  next_rep_idx = rep_idx + 1'b1;
            end
            else
               next_rep_pos = rep_pos + 1'b1;
         end
      end

      // Slow phase flips every N pixels, so one period is 2N pixels
      next_wide_cnt = '0;
      next_wide_phase = 1'b1;
      if (wide_on && !line_start)
      begin
         next_wide_cnt = wide_cnt;
         next_wide_phase = wide_phase;
         if (pixel_tick)
         begin
            if (wide_cnt + 1'b1 >= wide_clock_divider)
            begin
               next_wide_cnt = '0;
               next_wide_phase = !wide_phase;
            end
            else
               next_wide_cnt = wide_cnt + 1'b1;
         end
      end

      next_horizontal_blanking = blank_now;
      if (!blank_now)
      begin
         next_horiz_clock_phase_1 = first_half;
         next_horiz_clock_phase_2 = !first_half;
      end
      else if (blanking_mode_select == ccdhb_pkg::MODE_AREA)
      begin
         next_horiz_clock_phase_1 = hit_ph1 && first_half;
         next_horiz_clock_phase_2 = !(hit_ph2 && first_half);
      end
      else if (wide_on)
      begin
         next_horiz_clock_phase_1 = wide_phase;
         next_horiz_clock_phase_2 = !wide_phase;
      end
      else
      begin
         // Held in the parked state while blanked
         next_horiz_clock_phase_1 = 1'b0;
         next_horiz_clock_phase_2 = 1'b1;
      end
      next_optical_black_clamp = clamp_request &&
                                 !(line_odd ? clamp_line_mask_odd : clamp_line_mask_even);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pos <= ccdhb_pkg::POS_ZERO;
         line_odd <= 1'b1;
         rep_pos <= ccdhb_pkg::POS_ZERO;
         rep_idx <= ccdhb_pkg::POS_ZERO;
         wide_cnt <= '0;
         wide_phase <= 1'b1;
         horizontal_blanking <= 1'b0;
         horiz_clock_phase_1 <= 1'b0;
         horiz_clock_phase_2 <= 1'b1;
         optical_black_clamp <= 1'b0;
      end
      else
      begin
         pos <= next_pos;
         line_odd <= next_line_odd;
         rep_pos <= next_rep_pos;
         rep_idx <= next_rep_idx;
         wide_cnt <= next_wide_cnt;
         wide_phase <= next_wide_phase;
         horizontal_blanking <= next_horizontal_blanking;
         horiz_clock_phase_1 <= next_horiz_clock_phase_1;
         horiz_clock_phase_2 <= next_horiz_clock_phase_2;
         optical_black_clamp <= next_optical_black_clamp;
      end
   end
endmodule
`default_nettype wire

// File: ccdhb_pkg.sv
package ccdhb_pkg;
   localparam int POS_W = 13;
   localparam int AREAS = 6;
   localparam int TOGS = 6;
   localparam int CNT_W = 4;
   localparam int SEL_W = 3;
   localparam int WIDE_W = 4;
   localparam int MODE_W = 2;
   localparam int ADDR_W = 8;
   localparam int PIXEL_DIV = 2;
   localparam logic [POS_W-1:0] POS_MAX = 13'h1FFF;
   localparam logic [POS_W-1:0] POS_ZERO = 13'h0000;
   localparam logic [MODE_W-1:0] MODE_TOGGLE = 2'h0;
   localparam logic [MODE_W-1:0] MODE_REPEAT = 2'h1;
   localparam logic [MODE_W-1:0] MODE_AREA = 2'h2;
   localparam logic [ADDR_W-1:0] ADR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADR_BLK_START = 8'h04;
   localparam logic [ADDR_W-1:0] ADR_BLK_END = 8'h08;
   localparam logic [ADDR_W-1:0] ADR_BLK_LEN = 8'h0C;
   localparam logic [ADDR_W-1:0] ADR_BLK_REP = 8'h10;
   localparam logic [ADDR_W-1:0] ADR_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] ADR_WIDE = 8'h34;
   localparam logic [ADDR_W-1:0] ADR_TOG_EVEN = 8'h40;
   localparam logic [ADDR_W-1:0] ADR_TOG_ODD = 8'h58;
   localparam logic [ADDR_W-1:0] ADR_REP_PH1 = 8'h70;
   localparam logic [ADDR_W-1:0] ADR_REP_PH2 = 8'h88;
   localparam logic [ADDR_W-1:0] ADR_START_A = 8'hA0;
   localparam logic [ADDR_W-1:0] ADR_START_B = 8'hA4;
   localparam logic [ADDR_W-1:0] ADR_START_C = 8'hA8;
   localparam logic [ADDR_W-1:0] ADR_ALT_SEL = 8'hAC;
   localparam logic [ADDR_W-1:0] ARRAY_SPAN = 8'h18;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MASK_EVEN_BIT = 4;
   localparam int CTRL_MASK_ODD_BIT = 5;
   localparam int WIDE_LSB = 4;
   localparam int STATUS_ODD_BIT = 16;
   localparam int STATUS_BLANK_BIT = 17;
   localparam int REP_A_LSB = 0;
   localparam int REP_B_LSB = 4;
   localparam int REP_C_LSB = 8;
endpackage

// File: ccdhb_pixel_div.sv
`timescale 1ns/1ps
`default_nettype none
module ccdhb_pixel_div #(
   parameter int DIV = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   output logic pixel_tick,
   output logic first_half
);
   localparam int CW = $clog2(DIV) + 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] HALF = CW'(DIV / 2);
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;

   always_comb
   begin
      if (restart || cnt == LAST)
         next_cnt = '0;
      else
         next_cnt = cnt + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end

   assign pixel_tick = (cnt == LAST) && !restart;
   assign first_half = cnt < HALF;
endmodule
`default_nettype wire

// File: ccdhb_group_hit.sv
`timescale 1ns/1ps
`default_nettype none
module ccdhb_group_hit (
   input wire logic [ccdhb_pkg::POS_W-1:0] local_pos,
   input wire logic [ccdhb_pkg::POS_W-1:0] start_a,
   input wire logic [ccdhb_pkg::POS_W-1:0] start_b,
   input wire logic [ccdhb_pkg::POS_W-1:0] start_c,
   input wire logic [3*ccdhb_pkg::CNT_W-1:0] counts,
   output logic hit
);
   // Sums carry one extra bit so a start near the top cannot wrap
   logic [ccdhb_pkg::POS_W:0] end_a;
   logic [ccdhb_pkg::POS_W:0] end_b;
   logic [ccdhb_pkg::POS_W:0] end_c;

   always_comb
   begin
      end_a = {1'b0, start_a} + (ccdhb_pkg::POS_W+1)'(counts[ccdhb_pkg::REP_A_LSB +: ccdhb_pkg::CNT_W]);
      end_b = {1'b0, start_b} + (ccdhb_pkg::POS_W+1)'(counts[ccdhb_pkg::REP_B_LSB +: ccdhb_pkg::CNT_W]);
      end_c = {1'b0, start_c} + (ccdhb_pkg::POS_W+1)'(counts[ccdhb_pkg::REP_C_LSB +: ccdhb_pkg::CNT_W]);
      // A zero count gives an empty range
      hit = (local_pos >= start_a && {1'b0, local_pos} < end_a) ||
            (local_pos >= start_b && {1'b0, local_pos} < end_b) ||
            (local_pos >= start_c && {1'b0, local_pos} < end_c);
   end
endmodule
`default_nettype wire

// File: ccdhb_blank_gen_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ccdhb_blank_gen_asserts #(
   parameter int PIXEL_DIV = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic line_start,
   input wire logic clamp_request,
   input wire logic horizontal_blanking,
   input wire logic horiz_clock_phase_1,
   input wire logic optical_black_clamp
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc; psel && !penable ##1 psel && penable; endsequence
   property p_ack; s_acc |=> pready; endproperty
   property p_cause; pready |-> $past(psel && penable); endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_lat; pready |-> $past(psel, 2); endproperty
   property p_idle; !psel |=> !pready; endproperty
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   property p_clamp; optical_black_clamp |-> $past(clamp_request); endproperty
   // Restart and reset edges may repeat a phase level
   property p_rate; PIXEL_DIV == 2 && !horizontal_blanking && $past(!horizontal_blanking) && !$past(line_start)
      && !$past(line_start, 2) && $past(presetn, 2) |-> horiz_clock_phase_1 != $past(horiz_clock_phase_1); endproperty
   a_ack: assert property (p_ack) else $error("no answer after one wait state");
   a_cause: assert property (p_cause) else $error("ready without access");
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   a_lat: assert property (p_lat) else $error("ready without setup");
   a_idle: assert property (p_idle) else $error("ready while idle");
   a_err: assert property (p_err) else $error("error without zero data");
   a_clamp: assert property (p_clamp) else $error("clamp without request");
   a_rate: assert property (p_rate) else $error("clock not at pixel rate");
endmodule
bind ccdhb_blank_gen ccdhb_blank_gen_asserts #(.PIXEL_DIV(PIXEL_DIV)) chk_u (.pclk, .presetn, .psel, .penable,
   .prdata, .pready, .pslverr, .line_start, .clamp_request, .horizontal_blanking, .horiz_clock_phase_1,
   .optical_black_clamp);
`default_nettype wire

// File: ccdhb_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccdhb_sensor_model (
   input wire logic pclk,
   input wire logic clear,
   input wire logic horiz_clock_phase_1,
   input wire logic horizontal_blanking,
   output logic [15:0] blank_rises,
   output logic [15:0] period
);
   logic last = 1'b0;
   logic [15:0] since = 16'h0;
   // Charge moves one cell per phase 1 rise
   always @(posedge pclk)
   begin
      last <= horiz_clock_phase_1;
      since <= since + 16'h1;
      if (clear)
         blank_rises <= 16'h0;
      if (horiz_clock_phase_1 && !last)
      begin
         since <= 16'h1;
         period <= since;
         if (horizontal_blanking && !clear)
            blank_rises <= blank_rises + 16'h1;
      end
   end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("unexpected at %0t: got %h", $time, a); end end
module tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, line_start = 0, clamp_request = 1, e;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, blank, ph1, ph2, clamp;
   logic [15:0] rises, period;
   logic [39:0] cfg [11] = '{40'h00_00000012, 40'h04_00000000, 40'h08_0000012C, 40'h0C_00000032, 40'h10_00000006,
      40'h70_00000004, 40'h78_00000002, 40'h88_00000004, 40'h90_00000002, 40'hA0_00000003, 40'hAC_00000000};
   // No preblanking is driven; clamp_request is held high throughout, so clamp overlaps blanking
   int err_total = 0, checks = 0, d0, d1;
   initial forever #5 pclk = ~pclk;
   ccdhb_blank_gen dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .line_start, .clamp_request, .horizontal_blanking(blank), .horiz_clock_phase_1(ph1),
      .horiz_clock_phase_2(ph2), .optical_black_clamp(clamp));
   ccdhb_sensor_model ccd_u (.pclk, .clear(line_start), .horiz_clock_phase_1(ph1), .horizontal_blanking(blank),
      .blank_rises(rises), .period);
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so the next setup never re-raises psel in this step
      @(posedge pclk);
   endtask
   task automatic line(input int n);
      line_start <= 1'b1;
      @(posedge pclk) line_start <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask
   task automatic delay(output int d);
      line(4);
      for (d = 0; blank !== 1'b1 && d < 200; d++) @(posedge pclk);
   endtask
   task automatic summarize;
      if (err_total == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(0, ccdhb_pkg::ADR_WIDE, 0);
      `CHK(q, 32'h0)
      xfer(0, ccdhb_pkg::ADR_ALT_SEL, 0);
      `CHK(q, 32'h0002C688)
      xfer(0, 8'hFC, 0);
      `CHK(e, 1'b1)
      xfer(1, ccdhb_pkg::ADR_WIDE, 32'hFFFFFFFF);
      xfer(0, ccdhb_pkg::ADR_WIDE, 0);
      `CHK(q, 32'h000000F0)
      xfer(1, ccdhb_pkg::ADR_TOG_EVEN, 10);
      xfer(1, ccdhb_pkg::ADR_TOG_ODD, 20);
      delay(d0);
      delay(d1);
      `CHK(d1 - d0, 20)
      line(12);
      `CHK(period, 16'd2)
      repeat (200) @(posedge pclk);
      `CHK(period, 16'd60)
      // Starts B and C stay at 8191, unused
      foreach (cfg[i]) xfer(1, cfg[i][39:32], cfg[i][31:0]);
      line(5);
      `CHK(clamp, 1'b1)
      repeat (700) @(posedge pclk);
      `CHK(rises, 16'd24)
      line(5);
      `CHK(clamp, 1'b0)
      repeat (700) @(posedge pclk);
      `CHK(rises, 16'd6)
      summarize();
   end
   initial
   begin
      #60000;
      err_total++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
   end
endmodule
`default_nettype wire
